// file: gpmwf_map.svh
// Constant map for the general purpose pin block.
`ifndef GPMWF_MAP_SVH
`define GPMWF_MAP_SVH
`define GPMWF_NUM_PINS 9
`define GPMWF_FIRST_ANALOG 3
`define GPMWF_PIN_FAULT_IN 1
`define GPMWF_PIN_FAULT_OUT 2
`define GPMWF_PIN_WAKE 7
`define GPMWF_PIN_SCK 8
`define GPMWF_PIN_SDO 9
`define GPMWF_CLK_MHZ 200
`define GPMWF_WAKE_FILTER_NS 10000
`define GPMWF_WAKE_FILTER_CYC ((`GPMWF_WAKE_FILTER_NS * `GPMWF_CLK_MHZ + 999) / 1000)
`define GPMWF_ABS_LSB_UV 89
`define GPMWF_RATIO_LSB_LOG2 16
`define GPMWF_CODE_W 16
`endif

// file: gpmwf_pkg.sv
// Types shared by the general purpose pin block.
package gpmwf_pkg;
    // Two-bit pin mode field; digital input is binary 10.
    typedef enum logic [1:0]
    {
        GPMWF_CFG_DOUT = 2'h0,
        GPMWF_CFG_ANA = 2'h1,
        GPMWF_CFG_DIN = 2'h2,
        GPMWF_CFG_RSV = 2'h3
    } gpmwf_cfg_t;
    typedef enum logic [1:0]
    {
        GPMWF_PWR_LOW,
        GPMWF_PWR_WAKING,
        GPMWF_PWR_NORMAL
    } gpmwf_pwr_t;
endpackage

// file: gpmwf_sync.sv
// Three-stage input synchroniser with agreement filter.
module gpmwf_sync
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1Q;
    logic stage2Q;
    logic stage3Q;

    // Stage one is read only by stage two; output changes once two and three agree.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1Q <= 1'b0;
            stage2Q <= 1'b0;
            stage3Q <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            stage1Q <= asyncIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
            if (stage2Q == stage3Q)
            begin
                syncOut <= stage3Q;
            end
        end
    end
endmodule

// file: gpmwf_top.sv
// General purpose pin block: modes, lock, fault relay, wake control, analog selection.
`include "gpmwf_map.svh"
module gpmwf_top
    import gpmwf_pkg::*;
#(
    parameter int WAKE_FILTER_CYC = `GPMWF_WAKE_FILTER_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serial_port_select_pin,
    input wire logic [17:0] cfgWrData,
    input wire logic cfgWrStrobe,
    input wire logic pin7_wake_enable,
    input wire logic ratioModeSel,
    input wire logic [8:0] padIn,
    input wire logic convStart,
    input wire logic [8:0] padOutData,
    input wire logic serialOutData,
    input wire logic sleep_command,
    input wire logic commTimeout,
    input wire logic fault_in_pin,
    input wire logic chainFault,
    output logic [17:0] cfgRdData,
    output logic [8:0] padOut,
    output logic [8:0] padOeN,
    output logic [8:0] padDigIn,
    output logic [6:0] analogSampleSel,
    output logic analogRatioMode,
    output logic serial_clock_pin,
    output logic fault_out_pin,
    output logic faultSensed,
    output logic normalMode
);
    localparam logic [31:0] WakeCycles = 32'(WAKE_FILTER_CYC);

    logic [1:0] cfg_q [9];
    logic [1:0] cfg_d [9];
    logic [8:0] padSync;
    logic faultInSync;
    logic sckSync;
    logic [31:0] wakeCnt_q;
    gpmwf_pwr_t pwr_q;
    logic wakeSource;
    logic wakeHigh;

    // Pin 1 uses the fault sync; pin 8 clock edge data comes from sck sync.
    gpmwf_sync uFaultSync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .asyncIn(fault_in_pin),
        .syncOut(faultInSync)
    );

    // One synchroniser per pin input and one next-config value per pin.
    genvar gi;
    generate
        for (gi = 0; gi < `GPMWF_NUM_PINS; gi++)
        begin : gPin
            gpmwf_sync uPinSync
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .asyncIn(padIn[gi]),
                .syncOut(padSync[gi])
            );
            always_comb
            begin
                cfg_d[gi] = cfg_q[gi];
                if (gi + 1 == `GPMWF_PIN_FAULT_IN)
                begin
                    cfg_d[gi] = GPMWF_CFG_DIN;
                end
                else if (gi + 1 == `GPMWF_PIN_FAULT_OUT)
                begin
                    cfg_d[gi] = GPMWF_CFG_DOUT;
                end
                else if (serial_port_select_pin && gi + 1 == `GPMWF_PIN_SCK)
                begin
                    cfg_d[gi] = GPMWF_CFG_DIN;
                end
                else if (serial_port_select_pin && gi + 1 == `GPMWF_PIN_SDO)
                begin
                    cfg_d[gi] = GPMWF_CFG_DOUT;
                end
                else if (cfgWrStrobe)
                begin
                    cfg_d[gi] = cfgWrData[2*gi +: 2];
                    // Analog requests on pins without a converter path are refused.
                    if (gi + 1 < `GPMWF_FIRST_ANALOG && cfgWrData[2*gi +: 2] == GPMWF_CFG_ANA)
                    begin
                        cfg_d[gi] = cfg_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Serial clock pin sync, used as the serial clock toward the port logic.
    assign sckSync = padSync[`GPMWF_PIN_SCK-1];

    // Configuration state; reset gives defaults, first cycles settle them by select.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `GPMWF_NUM_PINS; i++)
            begin
                if (i + 1 == `GPMWF_PIN_FAULT_IN || i + 1 == `GPMWF_PIN_WAKE)
                begin
                    cfg_q[i] <= GPMWF_CFG_DIN;
                end
                else if (i + 1 == `GPMWF_PIN_FAULT_OUT)
                begin
                    cfg_q[i] <= GPMWF_CFG_DOUT;
                end
                else
                begin
                    cfg_q[i] <= GPMWF_CFG_ANA;
                end
            end
        end
        else
        begin
            for (int i = 0; i < `GPMWF_NUM_PINS; i++)
            begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    // Flags the first edge after reset; sleep requests are held off until then.
    logic resetDone_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resetDone_q <= 1'b0;
        end
        else
        begin
            resetDone_q <= 1'b1;
        end
    end

    // Pad drive, readback and serial routing.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            padOut <= 9'h000;
            padOeN <= 9'h1ff;
            padDigIn <= 9'h000;
            cfgRdData <= 18'h00000;
            analogSampleSel <= 7'h00;
            analogRatioMode <= 1'b0;
            serial_clock_pin <= 1'b0;
            fault_out_pin <= 1'b0;
            faultSensed <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `GPMWF_NUM_PINS; i++)
            begin
                padOut[i] <= padOutData[i];
                padOeN[i] <= (cfg_q[i] != GPMWF_CFG_DOUT);
                padDigIn[i] <= (cfg_q[i] == GPMWF_CFG_DIN) ? padSync[i] : 1'b0;
                cfgRdData[2*i +: 2] <= cfg_q[i];
            end
            if (serial_port_select_pin)
            begin
                padOut[`GPMWF_PIN_SDO-1] <= serialOutData;
            end
            padOut[`GPMWF_PIN_FAULT_OUT-1] <= faultInSync | chainFault;
            fault_out_pin <= faultInSync | chainFault;
            faultSensed <= faultInSync;
            serial_clock_pin <= serial_port_select_pin & sckSync;
            // Thresholds live elsewhere; the mode bit only steers the divider path.
            analogRatioMode <= ratioModeSel;
            for (int i = `GPMWF_FIRST_ANALOG - 1; i < `GPMWF_NUM_PINS; i++)
            begin
                analogSampleSel[i-(`GPMWF_FIRST_ANALOG-1)] <=
                    convStart && cfg_q[i] == GPMWF_CFG_ANA;
            end
        end
    end

    // Wake source qualification.
    assign wakeSource = cfg_q[`GPMWF_PIN_WAKE-1] == GPMWF_CFG_DIN && pin7_wake_enable;
    assign wakeHigh = wakeSource && padSync[`GPMWF_PIN_WAKE-1];

    // Wake filter counter and power state.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wakeCnt_q <= 32'h00000000;
            pwr_q <= GPMWF_PWR_NORMAL;
            normalMode <= 1'b1;
        end
        else
        begin
            case (pwr_q)
                GPMWF_PWR_LOW:
                begin
                    wakeCnt_q <= 32'h00000000;
                    if (wakeHigh)
                    begin
                        pwr_q <= GPMWF_PWR_WAKING;
                        wakeCnt_q <= 32'h00000001;
                    end
                end
                GPMWF_PWR_WAKING:
                begin
                    if (!wakeHigh)
                    begin
                        wakeCnt_q <= 32'h00000000;
                        pwr_q <= GPMWF_PWR_LOW;
                    end
                    else if (wakeCnt_q >= WakeCycles)
                    begin
                        pwr_q <= GPMWF_PWR_NORMAL;
                        normalMode <= 1'b1;
                    end
                    else
                    begin
                        wakeCnt_q <= wakeCnt_q + 32'h00000001;
                    end
                end
                GPMWF_PWR_NORMAL:
                begin
                    if (resetDone_q && !wakeHigh && (sleep_command || commTimeout))
                    begin
                        pwr_q <= GPMWF_PWR_LOW;
                        normalMode <= 1'b0;
                    end
                end
                default:
                begin
                    pwr_q <= GPMWF_PWR_NORMAL;
                end
            endcase
        end
    end
endmodule

// file: gpmwf_props.sv
// Port-level assertions for the general purpose pin block.
module gpmwf_props
#(
    parameter int WAKE_FILTER_CYC = 4
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serial_port_select_pin,
    input wire logic [17:0] cfgWrData,
    input wire logic cfgWrStrobe,
    input wire logic pin7_wake_enable,
    input wire logic ratioModeSel,
    input wire logic [8:0] padIn,
    input wire logic convStart,
    input wire logic sleep_command,
    input wire logic fault_in_pin,
    input wire logic chainFault,
    input wire logic [17:0] cfgRdData,
    input wire logic [8:0] padOeN,
    input wire logic [6:0] analogSampleSel,
    input wire logic analogRatioMode,
    input wire logic fault_out_pin,
    input wire logic faultSensed,
    input wire logic normalMode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Writes land two edges on, except on fixed or locked pins.
    a_fault_fixed: assert property (cfgWrStrobe |=> ##1 cfgRdData[3:0] == $past(cfgRdData[3:0], 2))
        else $error("fault pin mode moved");
    a_serial_lock: assert property ((cfgWrStrobe && serial_port_select_pin) |=>
        ##1 cfgRdData[17:14] == $past(cfgRdData[17:14], 2)) else $error("locked pin moved");
    a_write_lands: assert property ((cfgWrStrobe && !serial_port_select_pin) |=>
        ##1 cfgRdData[17:4] == $past(cfgWrData[17:4], 2)) else $error("mode not written");
    // Pin 7 drives only in output mode; sampling needs a conversion start.
    a_drive_mode: assert property (!padOeN[6] |-> cfgRdData[13:12] == 2'h0)
        else $error("pin driven outside output mode");
    a_sample_cause: assert property (analogSampleSel != 7'h0 |-> $past(convStart))
        else $error("sample without start");
    a_ratio_follow: assert property (ratioModeSel [*2] |-> analogRatioMode)
        else $error("ratio mode not followed");
    // Fault relay and wake control.
    a_fault_relay: assert property ($rose(chainFault) |-> ##[0:2] fault_out_pin)
        else $error("chain fault not relayed");
    a_fault_sense: assert property (fault_in_pin [*6] |-> ##[0:2] (faultSensed && fault_out_pin))
        else $error("fault input not relayed");
    a_wake_hold: assert property ((WAKE_FILTER_CYC <= 4 && padIn[6] && pin7_wake_enable &&
        cfgRdData[13:12] == 2'h2) [*8] |-> ##[0:4] normalMode) else $error("not awake");
    a_sleep_go: assert property ((!padIn[6]) [*6] ##0 sleep_command |=> !normalMode)
        else $error("sleep ignored");
endmodule
bind gpmwf_top gpmwf_props #(.WAKE_FILTER_CYC(WAKE_FILTER_CYC)) u_props (.clk_sys, .rst_n,
    .serial_port_select_pin, .cfgWrData, .cfgWrStrobe, .pin7_wake_enable, .ratioModeSel, .padIn,
    .convStart, .sleep_command, .fault_in_pin, .chainFault, .cfgRdData, .padOeN,
    .analogSampleSel, .analogRatioMode, .fault_out_pin, .faultSensed, .normalMode);

// file: gpmwf_host_model.sv
// Host and chain neighbour model driving the pads of the pin block.
module gpmwf_host_model
(
    input wire logic clk_sys,
    input wire logic [8:0] pinLvl,
    input wire logic sckRun,
    input wire logic fault_out_pin,
    output logic [8:0] padIn,
    output logic faultIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] sckDiv;
    // Pads move off the sampling edge; the serial clock stands still outside frames.
    // A running serial clock holds each level four cycles so the pad filter passes it.
    initial padIn = 9'h0;
    initial sckDiv = 2'h0;
    always @(negedge clk_sys)
    begin
        sckDiv <= sckDiv + 2'h1;
        if (!sckRun)
        begin
            padIn <= {pinLvl[8], pinLvl[7], pinLvl[6:0]};
        end
        else
        begin
            padIn <= {pinLvl[8], (sckDiv == 2'h3) ? ~padIn[7] : padIn[7], pinLvl[6:0]};
        end
    end
    // The bottom fault output serves as the host's fault interrupt.
    assign faultIrq = fault_out_pin;
endmodule

// file: tb_gpio_mux_wake_fault.sv
// Self-checking bench for the general purpose pin block.
module tb_gpio_mux_wake_fault;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_n, serial_port_select_pin, cfgWrStrobe, pin7_wake_enable, ratioModeSel;
    logic convStart, serialOutData, sleep_command, commTimeout, fault_in_pin, chainFault;
    logic sckRun, faultIrq, analogRatioMode, serial_clock_pin, fault_out_pin, faultSensed;
    logic normalMode;
    logic [17:0] cfgWrData, cfgRdData;
    logic [8:0] padIn, padOutData, padOut, padOeN, padDigIn, pinLvl;
    logic [6:0] analogSampleSel;
    int err_count, tests_run, cyc;
    gpmwf_top #(.WAKE_FILTER_CYC(4)) dut (.clk_sys, .rst_n, .serial_port_select_pin, .cfgWrData,
        .cfgWrStrobe, .pin7_wake_enable, .ratioModeSel, .padIn, .convStart, .padOutData,
        .serialOutData, .sleep_command, .commTimeout, .fault_in_pin, .chainFault, .cfgRdData,
        .padOut, .padOeN, .padDigIn, .analogSampleSel, .analogRatioMode, .serial_clock_pin,
        .fault_out_pin, .faultSensed, .normalMode);
    gpmwf_host_model host (.clk_sys, .pinLvl, .sckRun, .fault_out_pin, .padIn, .faultIrq);
    // Compares and counts.
    task automatic chk(string n, logic [17:0] s, logic [17:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic rst(logic sel);
        rst_n = 0;
        serial_port_select_pin = sel;
        tick(12);
        rst_n = 1;
        tick(3);
    endtask
    task automatic wr(logic [17:0] d);
        cfgWrData = d;
        cfgWrStrobe = 1;
        tick(1);
        cfgWrStrobe = 0;
        tick(2);
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bottom device: defaults, locking and the serial data pin.
    task automatic t_bottom();
        int rises;
        logic prevSck;
        rst(1);
        chk("cfg1", cfgRdData, 18'h0a552);
        wr(18'h15555);
        chk("lock", cfgRdData, 18'h09552);
        serialOutData = 1;
        tick(2);
        chk("sdo", padOut[8], 1'b1);
        sckRun = 1;
        tick(8);
        rises = 0;
        prevSck = serial_clock_pin;
        repeat (32)
        begin
            tick(1);
            if (serial_clock_pin && !prevSck)
                rises++;
            prevSck = serial_clock_pin;
        end
        sckRun = 0;
        chk("sck", 18'(rises), 18'h4);
    endtask
    // Digital output and input modes on every writable pin.
    task automatic t_digital();
        rst(0);
        chk("cfg0", cfgRdData, 18'h16552);
        wr(18'h0);
        chk("oe", padOeN[8:2], 7'h0);
        chk("out", padOut[8:2], 7'h6a);
        wr(18'h2aaaa);
        chk("in", cfgRdData, 18'h2aaa2);
        pinLvl = 9'h155;
        tick(6);
        chk("din", padDigIn[8:2], 7'h55);
    endtask
    // Analog selection and ratio mode.
    task automatic t_analog();
        wr(18'h15555);
        chk("ana", cfgRdData, 18'h15552);
        ratioModeSel = 0;
        convStart = 1;
        tick(1);
        convStart = 0;
        chk("abs", analogRatioMode, 1'b0);
        chk("smp0", analogSampleSel, 7'h7f);
        tick(1);
        chk("smpend", analogSampleSel, 7'h00);
        ratioModeSel = 1;
        convStart = 1;
        tick(1);
        convStart = 0;
        chk("smp", analogSampleSel, 7'h7f);
        chk("rat", analogRatioMode, 1'b1);
    endtask
    // Fault relay from both sources.
    task automatic t_fault();
        fault_in_pin = 1;
        tick(8);
        chk("irq", faultIrq, 1'b1);
        fault_in_pin = 0;
        chainFault = 1;
        tick(8);
        chk("sense", faultSensed, 1'b0);
        chk("relay", fault_out_pin, 1'b1);
        chk("pad2", padOut[1], 1'b1);
    endtask
    // Wake filter, wake gating and sleep blocking.
    task automatic t_wake();
        wr(18'h2aaaa);
        pinLvl = 9'h0;
        tick(6);
        sleep_command = 1;
        tick(1);
        sleep_command = 0;
        chk("slp", normalMode, 1'b0);
        pin7_wake_enable = 1;
        pinLvl = 9'h040;
        tick(3);
        pinLvl = 9'h0;
        tick(12);
        chk("glitch", normalMode, 1'b0);
        pin7_wake_enable = 0;
        pinLvl = 9'h040;
        tick(16);
        chk("gate", normalMode, 1'b0);
        pin7_wake_enable = 1;
        tick(12);
        chk("wake", normalMode, 1'b1);
        commTimeout = 1;
        tick(2);
        chk("hold", normalMode, 1'b1);
        pinLvl = 9'h0;
        tick(9);
        chk("tmo", normalMode, 1'b0);
    endtask
    // Clock, hang guard and main sequence.
    initial
    begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        {rst_n, serial_port_select_pin, cfgWrStrobe, pin7_wake_enable, ratioModeSel} = 5'h0;
        {convStart, serialOutData, sleep_command, commTimeout, fault_in_pin, chainFault} = 6'h0;
        {cfgWrData, padOutData, pinLvl, sckRun} = 37'h0;
        padOutData = 9'h1aa;
        t_bottom();
        t_digital();
        t_analog();
        t_fault();
        t_wake();
        final_report();
    end
endmodule
